// ==== lxd_pkg.sv ====
// shared types and constants for the x8 serial word receiver
package lxd_pkg;

    localparam int LXD_WORD_W = 8;
    localparam int LXD_LANE_W = 4;
    localparam int LXD_FIFO_DEPTH = 8;
    localparam int LXD_FIFO_AW = 3;

    localparam logic [1:0] LXD_PAIR_CNT_RST = 2'h0;
    localparam logic [1:0] LXD_PAIR_CNT_LAST = 2'h3;
    localparam logic [LXD_LANE_W-1:0] LXD_LANE_RST = 4'h0;
    localparam logic [LXD_WORD_W-1:0] LXD_WORD_RST = 8'h00;
    localparam logic [LXD_FIFO_AW:0] LXD_FIFO_CNT_RST = 4'h0;

    typedef logic [LXD_WORD_W-1:0] lxd_word_t;

    typedef struct packed {
        logic even;
        logic odd;
    } lxd_pair_t;

    typedef struct packed {
        logic [LXD_LANE_W-1:0] even;
        logic [LXD_LANE_W-1:0] odd;
    } lxd_lanes_t;

endpackage : lxd_pkg

// ==== lxd_ddr_capture.sv ====
// dual-edge input capture of the serial pin on the fast capture clock
`timescale 1ns/1ns
`default_nettype none
module lxd_ddr_capture
    import lxd_pkg::*;
(
    // fast clock domain
    input wire logic fast_capture_clock,
    input wire logic fast_rst_n,
    // serial pin
    input wire logic serial_in,
    // bit pair, both bits of one fast cycle
    output lxd_pair_t pair
);

    logic rise_bit;
    logic fall_bit;
    lxd_pair_t next_pair;

    // first stage: even bit on the rising edge, odd bit on the falling edge
    always_ff @(posedge fast_capture_clock or negedge fast_rst_n)
    begin
        if (!fast_rst_n)
            rise_bit <= 1'b0;
        else
            rise_bit <= serial_in;
    end

    always_ff @(negedge fast_capture_clock or negedge fast_rst_n)
    begin
        if (!fast_rst_n)
            fall_bit <= 1'b0;
        else
            fall_bit <= serial_in;
    end

    always_comb
    begin
        next_pair.even = rise_bit;
        next_pair.odd = fall_bit;
    end

    // second stage retimes both bits to the rising edge
    always_ff @(posedge fast_capture_clock or negedge fast_rst_n)
    begin
        if (!fast_rst_n)
            pair <= '0;
        else
            pair <= next_pair;
    end

endmodule : lxd_ddr_capture
`default_nettype wire

// ==== lxd_fifo.sv ====
// word fifo with registered output stage
`timescale 1ns/1ns
`default_nettype none
module lxd_fifo
    import lxd_pkg::*;
#(
    parameter int WIDTH = LXD_WORD_W,
    parameter int DEPTH = LXD_FIFO_DEPTH,
    parameter int AW = LXD_FIFO_AW
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic push;
    logic load;

    always_comb
    begin
        in_ready = (count != DEPTH[AW:0]);
        push = in_valid && in_ready;
        // refill the output stage when it is empty or being taken
        load = (!out_valid || out_ready) && (count != '0);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        next_out_data = load ? mem[rd_ptr] : out_data;
        if (load)
            next_out_valid = 1'b1;
        else if (out_ready)
            next_out_valid = 1'b0;
        else
            next_out_valid = out_valid;
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

endmodule : lxd_fifo
`default_nettype wire

// ==== lxd_receiver.sv ====
// high speed x8 serial receiver: capture, deserialize, cross to word clock, buffer
`timescale 1ns/1ns
`default_nettype none
module lxd_receiver
    import lxd_pkg::*;
(
    // word clock domain
    input wire logic mclk,
    input wire logic rst_n,
    // link side
    input wire logic fast_capture_clock,
    input wire logic serial_in,
    // parallel word output
    output lxd_word_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    // status
    output logic overrun
);

    // fast domain reset: asserted at once, released after two fast edges
    logic fast_rst_s1;
    logic fast_rst_n;

    always_ff @(posedge fast_capture_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fast_rst_s1 <= 1'b0;
            fast_rst_n <= 1'b0;
        end
        else
        begin
            fast_rst_s1 <= 1'b1;
            fast_rst_n <= fast_rst_s1;
        end
    end

    lxd_pair_t pair;

    lxd_ddr_capture u_capture (
        .fast_capture_clock(fast_capture_clock),
        .fast_rst_n(fast_rst_n),
        .serial_in(serial_in),
        .pair(pair)
    );

    // fast domain: shift registers, pair counter, word hold and request toggle
    lxd_lanes_t lanes;
    lxd_lanes_t next_lanes;
    logic [1:0] pair_cnt;
    logic [1:0] next_pair_cnt;
    lxd_word_t hold_word;
    lxd_word_t next_hold_word;
    lxd_word_t assembled;
    logic req_tgl;
    logic next_req_tgl;
    logic ovr_tgl;
    logic next_ovr_tgl;
    // one overrun report per held word keeps report toggles far enough apart to cross safely
    logic dropped;
    logic next_dropped;
    logic ack_tgl;
    logic ack_s1;
    logic ack_s2;
    logic pending;
    logic word_done;

    always_comb
    begin
        next_lanes.even = {lanes.even[LXD_LANE_W-2:0], pair.even};
        next_lanes.odd = {lanes.odd[LXD_LANE_W-2:0], pair.odd};
        next_pair_cnt = pair_cnt + 2'h1;
        word_done = (pair_cnt == LXD_PAIR_CNT_LAST);
        pending = req_tgl ^ ack_s2;
        next_hold_word = hold_word;
        next_req_tgl = req_tgl;
        next_ovr_tgl = ovr_tgl;
        next_dropped = dropped;
        if (word_done)
        begin
            // a word not yet taken by the word clock side is kept, the new one is dropped
            if (!pending)
            begin
                next_hold_word = assembled;
                next_req_tgl = !req_tgl;
                next_dropped = 1'b0;
            end
            else if (!dropped)
            begin
                next_ovr_tgl = !ovr_tgl;
                next_dropped = 1'b1;
            end
        end
    end

    // interleave: lane bit k lands in word bits 2k+1 (even) and 2k (odd)
    genvar gi;
    generate
        for (gi = 0; gi < LXD_LANE_W; gi++)
        begin : g_interleave
            assign assembled[2*gi+1] = next_lanes.even[gi];
            assign assembled[2*gi] = next_lanes.odd[gi];
        end
    endgenerate

    always_ff @(posedge fast_capture_clock or negedge fast_rst_n)
    begin
        if (!fast_rst_n)
        begin
            lanes <= '0;
            pair_cnt <= LXD_PAIR_CNT_RST;
            hold_word <= LXD_WORD_RST;
            req_tgl <= 1'b0;
            ovr_tgl <= 1'b0;
            dropped <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            lanes <= next_lanes;
            pair_cnt <= next_pair_cnt;
            hold_word <= next_hold_word;
            req_tgl <= next_req_tgl;
            ovr_tgl <= next_ovr_tgl;
            dropped <= next_dropped;
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // word clock domain: take the held word when its request toggle arrives
    logic req_s1;
    logic req_s2;
    logic next_ack_tgl;
    logic ovr_s1;
    logic ovr_s2;
    logic ovr_seen;
    logic next_overrun;
    lxd_word_t sync_word;
    lxd_word_t next_sync_word;
    logic sync_valid;
    logic next_sync_valid;
    logic fifo_in_ready;
    logic new_word;
    logic take;

    always_comb
    begin
        new_word = req_s2 ^ ack_tgl;
        // stall while the staged word cannot enter the fifo
        take = new_word && (!sync_valid || fifo_in_ready);
        next_ack_tgl = take ? req_s2 : ack_tgl;
        next_sync_word = take ? hold_word : sync_word;
        if (take)
            next_sync_valid = 1'b1;
        else if (fifo_in_ready)
            next_sync_valid = 1'b0;
        else
            next_sync_valid = sync_valid;
        next_overrun = ovr_s2 ^ ovr_seen;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack_tgl <= 1'b0;
            ovr_s1 <= 1'b0;
            ovr_s2 <= 1'b0;
            ovr_seen <= 1'b0;
            overrun <= 1'b0;
            sync_word <= LXD_WORD_RST;
            sync_valid <= 1'b0;
        end
        else
        begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            ack_tgl <= next_ack_tgl;
            ovr_s1 <= ovr_tgl;
            ovr_s2 <= ovr_s1;
            ovr_seen <= ovr_s2;
            overrun <= next_overrun;
            sync_word <= next_sync_word;
            sync_valid <= next_sync_valid;
        end
    end

    lxd_fifo #(
        .WIDTH(LXD_WORD_W),
        .DEPTH(LXD_FIFO_DEPTH),
        .AW(LXD_FIFO_AW)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .in_valid(sync_valid),
        .in_data(sync_word),
        .in_ready(fifo_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_word),
        .out_ready(rx_ready)
    );

endmodule : lxd_receiver
`default_nettype wire

// ==== lxd_receiver_props.sv ====
// port checks for the x8 serial receiver
`timescale 1ns/1ns
`default_nettype none
module lxd_receiver_props
    import lxd_pkg::*;
(
    // word clock domain
    input wire logic mclk,
    input wire logic rst_n,
    // word output
    input wire lxd_word_t rx_word,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic overrun
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_hold_valid; rx_valid && !rx_ready |=> rx_valid; endproperty
    a_hold_valid: assert property (p_hold_valid) else $error("valid lost untaken");
    property p_hold_word; rx_valid && !rx_ready |=> $stable(rx_word); endproperty
    a_hold_word: assert property (p_hold_word) else $error("word moved untaken");
    property p_ovr_pulse; overrun |=> !overrun; endproperty
    a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun too long");
    property p_rst_clear; $rose(rst_n) |-> !rx_valid && !overrun; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("flags set after reset");
    property p_rst_word; $rose(rst_n) |-> rx_word == 8'h00; endproperty
    a_rst_word: assert property (p_rst_word) else $error("word set after reset");
    property p_first_gap; $rose(rst_n) |-> !rx_valid [*4]; endproperty
    a_first_gap: assert property (p_first_gap) else $error("word too early");
    property p_live; $rose(rst_n) |-> ##[1:20] rx_valid; endproperty
    a_live: assert property (p_live) else $error("no word after reset");
    property p_refill; $fell(rx_valid) |-> ##[1:4] rx_valid; endproperty
    a_refill: assert property (p_refill) else $error("word stream stalled");
endmodule : lxd_receiver_props
bind lxd_receiver lxd_receiver_props u_lxd_receiver_props(.mclk(mclk), .rst_n(rst_n), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .overrun(overrun));
`default_nettype wire

// ==== lxd_tx_model.sv ====
// behavioural serial transmitter streaming one word over and over
`timescale 1ns/1ns
`default_nettype none
module lxd_tx_model
    import lxd_pkg::*;
(
    // link clock and reset as the receiver sees them
    input wire logic fast_capture_clock,
    input wire logic rst_n,
    // word to stream, serial line
    input wire lxd_word_t word,
    output logic serial_in
);
    int edges;
    int slot;
    logic run;
    initial serial_in = 1'b0;
    // data moves 3 ns after each edge, clear of the sampling edges
    always @(fast_capture_clock)
    begin
        run = rst_n;
        #3;
        if (!run)
            edges = 0;
        else if (fast_capture_clock)
            edges = edges + 1;
        // word boundary: the rising sample at the fifth rising link edge after reset release is the top bit
        slot = fast_capture_clock ? edges - 5 : edges - 4;
        if (!run || slot < 0)
            serial_in = ~serial_in;
        else
            serial_in = word[(fast_capture_clock ? 6 : 7) - 2 * (slot % 4)];
    end
endmodule : lxd_tx_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the x8 serial receiver
`timescale 1ns/1ns
`default_nettype none
module tb
    import lxd_pkg::*;
;
    logic mclk;
    logic fast_capture_clock;
    logic rst_n;
    logic serial_in;
    logic rx_valid;
    logic rx_ready;
    logic overrun;
    lxd_word_t rx_word;
    lxd_word_t tx_word;
    int err_total;
    int checked;
    lxd_word_t pats [6] = '{8'hc5, 8'h3a, 8'haa, 8'h55, 8'h81, 8'h7e};
    lxd_receiver u_lxd_receiver(.mclk(mclk), .rst_n(rst_n), .fast_capture_clock(fast_capture_clock),
        .serial_in(serial_in), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .overrun(overrun));
    lxd_tx_model u_lxd_tx_model(.fast_capture_clock(fast_capture_clock), .rst_n(rst_n), .word(tx_word),
        .serial_in(serial_in));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // 4 ns offset puts link edges on a 6 ns grid that still meets word clock edges, e.g. at 100 ns
    initial
    begin
        fast_capture_clock = 1'b0;
        #4;
        forever #6 fast_capture_clock = ~fast_capture_clock;
    end
    task automatic chk(input lxd_word_t seen, input lxd_word_t exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic take(input lxd_word_t exp, input int n);
        int got;
        int waited;
        got = 0;
        waited = 0;
        while (got < n && waited < 40)
        begin
            @(negedge mclk);
            waited++;
            if (rx_valid === 1'b1 && rx_ready === 1'b1)
            begin
                chk(rx_word, exp);
                got++;
            end
        end
        chk({7'h00, got == n}, 8'h01);
    endtask : take
    task automatic test_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk(rx_word, 8'h00);
        chk({6'h00, rx_valid, overrun}, 8'h00);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        take(tx_word, 4);
        $display("test reset done");
    endtask : test_reset
    task automatic test_patterns;
        foreach (pats[i])
        begin
            @(posedge mclk);
            tx_word <= pats[i];
            repeat (24) @(posedge mclk);
            take(pats[i], 6);
        end
        $display("test patterns done");
    endtask : test_patterns
    task automatic test_backpressure;
        logic seen;
        seen = 1'b0;
        @(posedge mclk);
        rx_ready <= 1'b0;
        repeat (30)
        begin
            @(negedge mclk);
            if (overrun === 1'b1)
                seen = 1'b1;
        end
        chk({7'h00, seen}, 8'h01);
        chk({7'h00, rx_valid}, 8'h01);
        @(posedge mclk);
        rx_ready <= 1'b1;
        take(tx_word, LXD_FIFO_DEPTH);
        $display("test backpressure done");
    endtask : test_backpressure
    initial
    begin
        rst_n = 1'b0;
        rx_ready = 1'b1;
        tx_word = pats[0];
        err_total = 0;
        checked = 0;
        test_reset();
        test_patterns();
        test_backpressure();
        test_reset();
        end_sim();
    end
    initial
    begin
        repeat (2000) @(posedge mclk);
        err_total++;
        $display("mismatch at %0t: run timed out", $time);
        end_sim();
    end
endmodule : tb
`default_nettype wire
